// ---- dds_defines.vh ----
`ifndef DDS_DEFINES_VH
`define DDS_DEFINES_VH
// Summary of operation
// - Mode field in control register 0x1F: 000 tone, 001 FSK, 010 ramp, 011 chirp, 100 BPSK; the core runs 001, 010 and 011 as single-tone.
// - Master reset selects single-tone; software may also write single-tone into mode field.
// - Single-tone accumulator increment is the 48-bit first frequency step word, reset zero.
// - Reset defaults give zero frequency and zero phase at the output.
// - After reset both DAC codes sit at midscale because default amplitude and control DAC value are zero.
// - Step word changes never reset the accumulator; phase continues smoothly.
// - Output fundamental spans zero up to half the core sample clock.
// - A 14-bit phase offset is added to accumulated phase before cosine lookup.
// - Amplitude has 12-bit control: fixed, rewritten, or shaped keying from one pin.
// - Two 14-bit phase offset registers; one pin selects between them for BPSK.
// - Settings update any time over byte-wide parallel port or serial port.
// - Core accepts new frequency settings at up to 100 million updates per second.
// - Core clock comes from reference directly or via a 4 to 20 multiplier.
// - Active-high master reset returns port and all registers to defaults.
// - Port select low picks serial programming, high picks parallel programming.

`define DDS_FSW_W       48
`define DDS_FSW_BYTES   6
`define DDS_PH_W        14
`define DDS_AMP_W       12
`define DDS_ADDR_W      6
`define DDS_IDX_W       12

`define DDS_A_PH1_HI    6'h00
`define DDS_A_PH1_LO    6'h01
`define DDS_A_PH2_HI    6'h02
`define DDS_A_PH2_LO    6'h03
`define DDS_A_FSW1      6'h04
`define DDS_A_CLK       6'h1e
`define DDS_A_MODE      6'h1f
`define DDS_A_AMPCTL    6'h20
`define DDS_A_AMP_HI    6'h21
`define DDS_A_AMP_LO    6'h22
`define DDS_A_KRATE     6'h23
`define DDS_A_CDAC_HI   6'h24
`define DDS_A_CDAC_LO   6'h25
`define DDS_A_ANOW_HI   6'h26
`define DDS_A_ANOW_LO   6'h27

`define DDS_MODE_MSB    2
`define DDS_MODE_LSB    0
`define DDS_MODE_SINGLE 3'h0
`define DDS_MODE_FSK    3'h1
`define DDS_MODE_RFSK   3'h2
`define DDS_MODE_CHIRP  3'h3
`define DDS_MODE_BPSK   3'h4

`define DDS_CLK_BYP_BIT 5
`define DDS_MULT_MSB    4
`define DDS_MULT_LSB    0
`define DDS_MULT_RST    5'h04
`define DDS_MULT_MIN    5'h04
`define DDS_MULT_MAX    5'h14
`define DDS_BYP_RST     1'b1
`define DDS_KEY_EN_BIT  0

`define DDS_MIDSCALE    12'h800
`define DDS_AMP_STEP    12'h001
`define DDS_COS_MAX     11'h7ff

`define DDS_SER_RD_BIT  7
`define DDS_SER_LAST    3'h7

`define DDS_PIN_W       23
`define DDS_PIN_IDLE    23'h700000
`endif

// ---- dds_cos_shaper.v ----
`include "dds_defines.vh"

// Parabolic cosine: about 6 % peak error, traded for having no table
module dds_cos_shaper (
  // Phase in, full turn over the index range
  input  wire [`DDS_IDX_W-1:0] phase_idx,
  // Signed cosine sample
  output reg  [`DDS_AMP_W-1:0] cos_val
);

  reg [9:0]  u;
  reg [19:0] sq;
  reg [10:0] mag;

  always @* begin
    // Odd quadrants mirror the argument, quadrants 1 and 2 negate
    u = phase_idx[10] ? ~phase_idx[9:0] : phase_idx[9:0];
    sq = u * u;
    mag = `DDS_COS_MAX - sq[19:9];
    if (phase_idx[11] ^ phase_idx[10]) begin
      cos_val = -{1'b0, mag};
    end else begin
      cos_val = {1'b0, mag};
    end
  end

endmodule // dds_cos_shaper

// ---- dds_nco_core.v ----
`include "dds_defines.vh"

module dds_nco_core (
  // Clock, reset, enable
  input  wire        clk_sys,
  input  wire        rst_b,
  input  wire        ce,
  // Device pins: master reset and port select
  input  wire        master_reset,
  input  wire        ps_sel,
  // Parallel programming port
  input  wire [5:0]  par_addr,
  input  wire [7:0]  par_data_in,
  output reg  [7:0]  par_data_out,
  output reg         par_data_oe,
  input  wire        par_wr_b,
  input  wire        par_rd_b,
  // Serial programming port
  input  wire        ser_cs_b,
  input  wire        ser_sclk,
  input  wire        ser_sdi,
  output reg         ser_sdo,
  output reg         ser_sdo_oe,
  // Modulation pins
  input  wire        key_pin,
  input  wire        psk_pin,
  // DAC codes
  output reg  [11:0] cos_dac_code,
  output reg  [11:0] ctl_dac_code,
  // Clock generator controls
  output reg         pll_bypass,
  output reg  [4:0]  pll_mult
);

  localparam [2:0] SP_INSTR = 3'b001;
  localparam [2:0] SP_DATA  = 3'b010;
  localparam [2:0] SP_DONE  = 3'b100;

  // Pin synchronisers; strobes idle high so no false edge after reset
  reg [`DDS_PIN_W-1:0] pin_s1_q;
  reg [`DDS_PIN_W-1:0] pin_s2_q;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_q <= `DDS_PIN_IDLE;
      pin_s2_q <= `DDS_PIN_IDLE;
    end else if (ce) begin
      pin_s1_q <= {ser_cs_b, par_rd_b, par_wr_b, ps_sel, master_reset, ser_sclk,
                   ser_sdi, key_pin, psk_pin, par_addr, par_data_in};
      pin_s2_q <= pin_s1_q;
    end
  end

  wire       cs_b_s  = pin_s2_q[22];
  wire       rd_b_s  = pin_s2_q[21];
  wire       wr_b_s  = pin_s2_q[20];
  wire       psel_s  = pin_s2_q[19];
  wire       mrst_s  = pin_s2_q[18];
  wire       sclk_s  = pin_s2_q[17];
  wire       sdi_s   = pin_s2_q[16];
  wire       key_s   = pin_s2_q[15];
  wire       psk_s   = pin_s2_q[14];
  wire [5:0] paddr_s = pin_s2_q[13:8];
  wire [7:0] pdata_s = pin_s2_q[7:0];

  reg wr_prev_q;
  reg sclk_prev_q;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_prev_q   <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else if (ce) begin
      wr_prev_q   <= wr_b_s;
      sclk_prev_q <= sclk_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_prev_q;
  wire sclk_fall = ~sclk_s & sclk_prev_q;

  // Programming registers
  reg [`DDS_FSW_W-1:0] fsw1_q;
  reg [`DDS_PH_W-1:0]  ph1_q;
  reg [`DDS_PH_W-1:0]  ph2_q;
  reg [2:0]            mode_q;
  reg                  key_en_q;
  reg [`DDS_AMP_W-1:0] amp_q;
  reg [7:0]            krate_q;
  reg [`DDS_AMP_W-1:0] cdac_q;
  reg [`DDS_AMP_W-1:0] amp_now_q;

  // Serial port state
  reg [2:0] sp_state_q;
  reg [2:0] sp_cnt_q;
  reg [7:0] sp_shift_q;
  reg [7:0] sp_instr_q;
  reg [7:0] sp_out_q;

  wire [7:0] sp_byte = {sp_shift_q[6:0], sdi_s};
  wire       sp_last = sclk_rise & (sp_cnt_q == `DDS_SER_LAST);

  // One write path, steered by the port select pin
  wire       par_wr = psel_s & wr_b_s & ~wr_prev_q;
  wire       ser_wr = ~psel_s & ~cs_b_s & (sp_state_q == SP_DATA) & sp_last
                      & ~sp_instr_q[`DDS_SER_RD_BIT];
  wire       wr_en   = par_wr | ser_wr;
  wire [5:0] wr_addr = psel_s ? paddr_s : sp_instr_q[5:0];
  wire [7:0] wr_data = psel_s ? pdata_s : sp_byte;
  wire [5:0] rd_addr = psel_s ? paddr_s : sp_byte[5:0];

  // Register read mux; unmapped addresses read zero
  reg [7:0] rd_data;
  integer   k;

  always @* begin
    rd_data = 8'h00;
    case (rd_addr)
      `DDS_A_PH1_HI:  rd_data = {2'h0, ph1_q[13:8]};
      `DDS_A_PH1_LO:  rd_data = ph1_q[7:0];
      `DDS_A_PH2_HI:  rd_data = {2'h0, ph2_q[13:8]};
      `DDS_A_PH2_LO:  rd_data = ph2_q[7:0];
      `DDS_A_CLK:     rd_data = {2'h0, pll_bypass, pll_mult};
      `DDS_A_MODE:    rd_data = {5'h00, mode_q};
      `DDS_A_AMPCTL:  rd_data = {7'h00, key_en_q};
      `DDS_A_AMP_HI:  rd_data = {4'h0, amp_q[11:8]};
      `DDS_A_AMP_LO:  rd_data = amp_q[7:0];
      `DDS_A_KRATE:   rd_data = krate_q;
      `DDS_A_CDAC_HI: rd_data = {4'h0, cdac_q[11:8]};
      `DDS_A_CDAC_LO: rd_data = cdac_q[7:0];
      `DDS_A_ANOW_HI: rd_data = {4'h0, amp_now_q[11:8]};
      `DDS_A_ANOW_LO: rd_data = amp_now_q[7:0];
      default:        rd_data = 8'h00;
    endcase
    for (k = 0; k < `DDS_FSW_BYTES; k = k + 1) begin
      if (rd_addr == `DDS_A_FSW1 + k[5:0]) begin
        rd_data = fsw1_q[`DDS_FSW_W-1-8*k -: 8];
      end
    end
  end

  // Register writes; master reset returns every field to its default
  integer i;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fsw1_q     <= {`DDS_FSW_W{1'b0}};
      ph1_q      <= {`DDS_PH_W{1'b0}};
      ph2_q      <= {`DDS_PH_W{1'b0}};
      mode_q     <= `DDS_MODE_SINGLE;
      key_en_q   <= 1'b0;
      amp_q      <= {`DDS_AMP_W{1'b0}};
      krate_q    <= 8'h00;
      cdac_q     <= {`DDS_AMP_W{1'b0}};
      pll_bypass <= `DDS_BYP_RST;
      pll_mult   <= `DDS_MULT_RST;
    end else if (ce) begin
      if (mrst_s) begin
        fsw1_q     <= {`DDS_FSW_W{1'b0}};
        ph1_q      <= {`DDS_PH_W{1'b0}};
        ph2_q      <= {`DDS_PH_W{1'b0}};
        mode_q     <= `DDS_MODE_SINGLE;
        key_en_q   <= 1'b0;
        amp_q      <= {`DDS_AMP_W{1'b0}};
        krate_q    <= 8'h00;
        cdac_q     <= {`DDS_AMP_W{1'b0}};
        pll_bypass <= `DDS_BYP_RST;
        pll_mult   <= `DDS_MULT_RST;
      end else if (wr_en) begin
        case (wr_addr)
          `DDS_A_PH1_HI:  ph1_q[13:8] <= wr_data[5:0];
          `DDS_A_PH1_LO:  ph1_q[7:0] <= wr_data;
          `DDS_A_PH2_HI:  ph2_q[13:8] <= wr_data[5:0];
          `DDS_A_PH2_LO:  ph2_q[7:0] <= wr_data;
          `DDS_A_MODE:    mode_q <= wr_data[`DDS_MODE_MSB:`DDS_MODE_LSB];
          `DDS_A_AMPCTL:  key_en_q <= wr_data[`DDS_KEY_EN_BIT];
          `DDS_A_AMP_HI:  amp_q[11:8] <= wr_data[3:0];
          `DDS_A_AMP_LO:  amp_q[7:0] <= wr_data;
          `DDS_A_KRATE:   krate_q <= wr_data;
          `DDS_A_CDAC_HI: cdac_q[11:8] <= wr_data[3:0];
          `DDS_A_CDAC_LO: cdac_q[7:0] <= wr_data;
          `DDS_A_CLK: begin
            pll_bypass <= wr_data[`DDS_CLK_BYP_BIT];
            // Out-of-range multipliers are clamped into the legal span
            if (wr_data[`DDS_MULT_MSB:`DDS_MULT_LSB] < `DDS_MULT_MIN) begin
              pll_mult <= `DDS_MULT_MIN;
            end else if (wr_data[`DDS_MULT_MSB:`DDS_MULT_LSB] > `DDS_MULT_MAX) begin
              pll_mult <= `DDS_MULT_MAX;
            end else begin
              pll_mult <= wr_data[`DDS_MULT_MSB:`DDS_MULT_LSB];
            end
          end
          default: begin
          end
        endcase
        // Each byte lands at once, so one cycle per byte update
        for (i = 0; i < `DDS_FSW_BYTES; i = i + 1) begin
          if (wr_addr == `DDS_A_FSW1 + i[5:0]) begin
            fsw1_q[`DDS_FSW_W-1-8*i -: 8] <= wr_data;
          end
        end
      end
    end
  end

  // Parallel read data, registered; bus driven only while read strobe low
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      par_data_out <= 8'h00;
      par_data_oe  <= 1'b0;
    end else if (ce) begin
      par_data_out <= rd_data;
      par_data_oe  <= psel_s & ~rd_b_s & ~mrst_s;
    end
  end

  // Serial port: instruction byte, then one data byte, MSB first
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sp_state_q <= SP_INSTR;
      sp_cnt_q   <= 3'h0;
      sp_shift_q <= 8'h00;
      sp_instr_q <= 8'h00;
      sp_out_q   <= 8'h00;
      ser_sdo    <= 1'b0;
      ser_sdo_oe <= 1'b0;
    end else if (ce) begin
      if (mrst_s | cs_b_s | psel_s) begin
        sp_state_q <= SP_INSTR;
        sp_cnt_q   <= 3'h0;
        ser_sdo_oe <= 1'b0;
      end else begin
        if (sclk_rise) begin
          sp_shift_q <= sp_byte;
          sp_cnt_q   <= sp_cnt_q + 3'h1;
        end
        case (sp_state_q)
          SP_INSTR: begin
            if (sp_last) begin
              sp_instr_q <= sp_byte;
              sp_state_q <= SP_DATA;
              if (sp_byte[`DDS_SER_RD_BIT]) begin
                sp_out_q   <= rd_data;
                ser_sdo_oe <= 1'b1;
              end
            end
          end
          SP_DATA: begin
            // Read bits change on falling edges for the host to sample on rising
            if (sclk_fall & ser_sdo_oe) begin
              ser_sdo  <= sp_out_q[7];
              sp_out_q <= {sp_out_q[6:0], 1'b0};
            end
            if (sp_last) begin
              sp_state_q <= SP_DONE;
            end
          end
          SP_DONE: begin
            if (sclk_fall & ser_sdo_oe) begin
              ser_sdo <= 1'b0;
            end
          end
          default: sp_state_q <= SP_INSTR;
        endcase
      end
    end
  end

  // Shaped keying: amplitude walks one step per rate period toward its target
  reg [7:0] key_cnt_q;
  wire [`DDS_AMP_W-1:0] key_target = key_s ? amp_q : {`DDS_AMP_W{1'b0}};

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      key_cnt_q <= 8'h00;
      amp_now_q <= {`DDS_AMP_W{1'b0}};
    end else if (ce) begin
      if (mrst_s) begin
        key_cnt_q <= 8'h00;
        amp_now_q <= {`DDS_AMP_W{1'b0}};
      end else if (!key_en_q) begin
        key_cnt_q <= 8'h00;
        amp_now_q <= amp_q;
      end else if (key_cnt_q != 8'h00) begin
        key_cnt_q <= key_cnt_q - 8'h01;
      end else begin
        key_cnt_q <= krate_q;
        if (amp_now_q < key_target) begin
          amp_now_q <= amp_now_q + `DDS_AMP_STEP;
        end else if (amp_now_q > key_target) begin
          amp_now_q <= amp_now_q - `DDS_AMP_STEP;
        end
      end
    end
  end

  // Phase accumulator; never cleared by tuning, wraps at 2^48
  reg [`DDS_FSW_W-1:0] acc_q;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      acc_q <= {`DDS_FSW_W{1'b0}};
    end else if (ce) begin
      if (mrst_s) begin
        acc_q <= {`DDS_FSW_W{1'b0}};
      end else begin
        // Top bit of the step word reaches half the clock rate
        acc_q <= acc_q + fsw1_q;
      end
    end
  end

  // Only BPSK honours the select pin; reserved codes stay single-tone
  wire use_ph2 = (mode_q == `DDS_MODE_BPSK) & psk_s;
  wire [`DDS_PH_W-1:0] phase = acc_q[`DDS_FSW_W-1 -: `DDS_PH_W] + (use_ph2 ? ph2_q : ph1_q);

  wire [`DDS_AMP_W-1:0] cos_val;

  dds_cos_shaper u_cos (
    .phase_idx (phase[`DDS_PH_W-1 -: `DDS_IDX_W]),
    .cos_val   (cos_val)
  );

  wire signed [24:0] prod = $signed(cos_val) * $signed({1'b0, amp_now_q});

  // Offset binary DAC codes: zero scale lands on midscale
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cos_dac_code <= `DDS_MIDSCALE;
      ctl_dac_code <= `DDS_MIDSCALE;
    end else if (ce) begin
      cos_dac_code <= prod[23:12] + `DDS_MIDSCALE;
      ctl_dac_code <= cdac_q + `DDS_MIDSCALE;
    end
  end

endmodule // dds_nco_core

// ---- dds_nco_checker.sv ----
module dds_nco_checker (
  // Clock and reset
  input logic        clk_sys,
  input logic        rst_b,
  // Pins
  input logic        master_reset,
  input logic        ps_sel,
  input logic [5:0]  par_addr,
  input logic        par_wr_b,
  input logic        par_rd_b,
  input logic        ser_cs_b,
  // Outputs
  input logic [7:0]  par_data_out,
  input logic        par_data_oe,
  input logic        ser_sdo_oe,
  input logic [11:0] cos_dac_code,
  input logic [11:0] ctl_dac_code,
  input logic        pll_bypass,
  input logic [4:0]  pll_mult
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_reset_mid;
    !$past(rst_b) |-> cos_dac_code == 12'h800 && ctl_dac_code == 12'h800;
  endproperty
  a_reset_mid: assert property (p_reset_mid)
    else $error("dac codes off midscale after reset");

  property p_mreset;
    master_reset [*4] |=> pll_bypass && pll_mult == 5'h04 && cos_dac_code == 12'h800;
  endproperty
  a_mreset: assert property (p_mreset)
    else $error("master reset left non-default outputs");

  property p_mult_range;
    pll_mult >= 5'h04 && pll_mult <= 5'h14;
  endproperty
  a_mult_range: assert property (p_mult_range)
    else $error("multiplier outside 4 to 20");

  // Sync pipeline gives a fixed three-cycle lag from pins to the enable
  property p_oe_cause;
    par_data_oe == ($past(ps_sel, 3) && !$past(par_rd_b, 3) && !$past(master_reset, 3));
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("parallel output enable wrong");

  property p_sdo_oe;
    ser_sdo_oe |-> !$past(ser_cs_b, 3) && !$past(ps_sel, 3);
  endproperty
  a_sdo_oe: assert property (p_sdo_oe)
    else $error("serial output enabled outside a serial frame");

  property p_one_driver;
    !(par_data_oe && ser_sdo_oe);
  endproperty
  a_one_driver: assert property (p_one_driver)
    else $error("both ports drive at once");

  property p_idle_stable;
    (ser_cs_b && par_wr_b && !master_reset) [*8] |->
      $stable(pll_mult) && $stable(pll_bypass) && $stable(ctl_dac_code);
  endproperty
  a_idle_stable: assert property (p_idle_stable)
    else $error("settings changed without a write");

  property p_unmapped;
    // Only the parallel port reads by pin address
    (ps_sel && par_addr == 6'h3f) [*5] |-> par_data_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped address read nonzero");

  property p_mode_read;
    (ps_sel && par_addr == 6'h1f) [*5] |-> par_data_out[7:3] == 5'h00;
  endproperty
  a_mode_read: assert property (p_mode_read)
    else $error("unused mode bits read nonzero");

  c_par_read: cover property (par_data_oe);
  c_ser_read: cover property (ser_sdo_oe);
  c_mreset: cover property (master_reset [*4]);
endmodule // dds_nco_checker

bind dds_nco_core dds_nco_checker u_chk (
  .clk_sys, .rst_b, .master_reset, .ps_sel, .par_addr, .par_wr_b, .par_rd_b, .ser_cs_b,
  .par_data_out, .par_data_oe, .ser_sdo_oe, .cos_dac_code, .ctl_dac_code, .pll_bypass,
  .pll_mult
);

// ---- dds_host_model.sv ----
module dds_host_model (
  // Clock
  input  logic       clk_sys,
  // Parallel port
  output logic       ps_sel,
  output logic [5:0] par_addr,
  output logic [7:0] par_data_in,
  output logic       par_wr_b,
  output logic       par_rd_b,
  input  logic [7:0] par_data_out,
  input  logic       par_data_oe,
  // Serial port
  output logic       ser_cs_b,
  output logic       ser_sclk,
  output logic       ser_sdi,
  input  logic       ser_sdo,
  input  logic       ser_sdo_oe
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    ps_sel = 1'b1;
    par_addr = 6'h00;
    par_data_in = 8'h00;
    par_wr_b = 1'b1;
    par_rd_b = 1'b1;
    ser_cs_b = 1'b1;
    ser_sclk = 1'b0;
    ser_sdi = 1'b0;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic sel_port(input logic s);
    ps_sel = s;
  endtask

  // Strobe held well past the three-cycle sync window on both edges
  task automatic par_wr(input logic [5:0] a, input logic [7:0] d);
    gap(1);
    par_addr = a;
    par_data_in = d;
    par_wr_b = 1'b0;
    gap(4);
    par_wr_b = 1'b1;
    gap(6);
    par_data_in = ~d;
  endtask

  task automatic par_rd(input logic [5:0] a, output logic [7:0] d, output logic oe);
    gap(1);
    par_addr = a;
    par_rd_b = 1'b0;
    gap(6);
    d = par_data_out;
    oe = par_data_oe;
    par_rd_b = 1'b1;
    gap(4);
  endtask

  // Read bits are taken just before each rising clock of the data phase
  task automatic ser_xfer(input logic [7:0] ins, input logic [7:0] d,
                          output logic [7:0] q);
    logic [15:0] w;
    w = {ins, d};
    q = 8'h00;
    gap(1);
    ser_cs_b = 1'b0;
    gap(4);
    for (int i = 15; i >= 0; i--) begin
      ser_sdi = w[i];
      gap(6);
      if (i < 8) q[i] = ser_sdo;
      ser_sclk = 1'b1;
      gap(4);
      ser_sclk = 1'b0;
    end
    gap(4);
    ser_cs_b = 1'b1;
    ser_sdi = ~ser_sdi;
    gap(6);
  endtask
endmodule // dds_host_model

// ---- tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, rst_b, ce, master_reset, key_pin, psk_pin, ps_sel, oe;
  logic        par_wr_b, par_rd_b, par_data_oe, ser_cs_b, ser_sclk, ser_sdi;
  logic        ser_sdo, ser_sdo_oe, pll_bypass;
  logic [5:0]  par_addr;
  logic [7:0]  par_data_in, par_data_out, rd, q;
  logic [11:0] cos_dac_code, ctl_dac_code, a;
  logic [4:0]  pll_mult;
  logic [7:0]  clk_wr [3] = '{8'h0a, 8'h23, 8'h1f};
  logic [4:0]  clk_mult [3] = '{5'h0a, 5'h04, 5'h14};
  int          miscompares, total_checks, cyc;

  dds_nco_core uut (
    .clk_sys, .rst_b, .ce, .master_reset, .ps_sel, .par_addr, .par_data_in, .par_data_out,
    .par_data_oe, .par_wr_b, .par_rd_b, .ser_cs_b, .ser_sclk, .ser_sdi, .ser_sdo,
    .ser_sdo_oe, .key_pin, .psk_pin, .cos_dac_code, .ctl_dac_code, .pll_bypass, .pll_mult
  );
  dds_host_model host (
    .clk_sys, .ps_sel, .par_addr, .par_data_in, .par_wr_b, .par_rd_b, .par_data_out,
    .par_data_oe, .ser_cs_b, .ser_sclk, .ser_sdi, .ser_sdo, .ser_sdo_oe
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic rd_chk(input logic [5:0] ad, input logic [7:0] e);
    host.par_rd(ad, rd, oe);
    chk("read data", rd, e);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Whole sequence needs about 950 cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    master_reset = 1'b0;
    key_pin = 1'b0;
    psk_pin = 1'b0;
    wait_clk(16);
    rst_b = 1'b1;
    wait_clk(4);
    chk("cos code", cos_dac_code, 12'h800);
    chk("ctl code", ctl_dac_code, 12'h800);
    rd_chk(6'h1f, 8'h00);
    chk("read enable", oe, 1'b1);
    rd_chk(6'h1e, 8'h24);
    for (int i = 4; i < 10; i++) rd_chk(6'(i), 8'h00);
    $display("test defaults done");
    foreach (clk_wr[i]) begin
      host.par_wr(6'h1e, clk_wr[i]);
      chk("pll mult", pll_mult, clk_mult[i]);
      chk("pll bypass", pll_bypass, clk_wr[i][5]);
    end
    host.par_wr(6'h3f, 8'h5a);
    rd_chk(6'h3f, 8'h00);
    $display("test clock and unmapped done");
    host.par_wr(6'h21, 8'h0f);
    host.par_wr(6'h22, 8'hff);
    host.par_wr(6'h02, 8'h20);
    psk_pin = 1'b1;
    for (int m = 0; m < 8; m++) begin
      host.par_wr(6'h1f, 8'(m));
      wait_clk(8);
      chk("cos sign", cos_dac_code[11], m != 4);
    end
    host.par_wr(6'h1f, 8'h04);
    psk_pin = 1'b0;
    wait_clk(8);
    chk("cos sign", cos_dac_code[11], 1'b1);
    host.par_wr(6'h00, 8'h20);
    wait_clk(8);
    chk("cos sign", cos_dac_code[11], 1'b0);
    host.par_wr(6'h00, 8'h00);
    host.par_wr(6'h24, 8'h08);
    host.par_wr(6'h25, 8'h00);
    chk("ctl code", ctl_dac_code, 12'h000);
    $display("test phase and mode done");
    // Half the core rate: 0.5 times 2^48
    host.par_wr(6'h04, 8'h80);
    wait_clk(4);
    a = cos_dac_code;
    wait_clk(1);
    chk("cos alternates", a[11] ^ cos_dac_code[11], 1'b1);
    // Enable low must freeze the running accumulator
    ce = 1'b0;
    a = cos_dac_code;
    wait_clk(3);
    chk("cos frozen", cos_dac_code, a);
    ce = 1'b1;
    host.par_wr(6'h04, 8'h00);
    a = cos_dac_code;
    wait_clk(3);
    chk("cos held", cos_dac_code, a);
    $display("test frequency done");
    host.par_wr(6'h21, 8'h00);
    host.par_wr(6'h22, 8'h05);
    host.par_wr(6'h20, 8'h01);
    key_pin = 1'b1;
    wait_clk(20);
    rd_chk(6'h27, 8'h05);
    key_pin = 1'b0;
    wait_clk(20);
    rd_chk(6'h27, 8'h00);
    chk("cos code", cos_dac_code, 12'h800);
    $display("test keying done");
    master_reset = 1'b1;
    wait_clk(5);
    master_reset = 1'b0;
    wait_clk(4);
    chk("pll mult", pll_mult, 5'h04);
    rd_chk(6'h1f, 8'h00);
    rd_chk(6'h22, 8'h00);
    $display("test master reset done");
    host.sel_port(1'b0);
    wait_clk(4);
    host.par_wr(6'h1e, 8'h0a);
    chk("pll mult", pll_mult, 5'h04);
    host.ser_xfer(8'h1e, 8'h0b, q);
    chk("pll mult", pll_mult, 5'h0b);
    host.ser_xfer(8'h9e, 8'h00, q);
    chk("serial read", q, 8'h0b);
    host.par_rd(6'h1e, rd, oe);
    chk("read enable", oe, 1'b0);
    $display("test serial done");
    finish_test();
  end
endmodule // tb
